// ### hw/arfr_consts.svh
// Constants for the architectural register file with rename buffers
`ifndef ARFR_CONSTS_SVH
`define ARFR_CONSTS_SVH
`define ARFR_NUM_REGS 32
`define ARFR_REG_IDX_W 5
`define ARFR_INT_W 32
`define ARFR_FP_W 64
`define ARFR_INT_RB 12
`define ARFR_INT_TAG_W 4
`define ARFR_INT_TAG_LAST 4'hB
`define ARFR_FP_RB 8
`define ARFR_FP_TAG_W 3
`define ARFR_FP_TAG_LAST 3'h7
`define ARFR_SPR_NUM_W 10
`define ARFR_SPR_PRIV_BIT 4
`define ARFR_SPR_USER_NUM 10'h100
`define ARFR_SPR_SUP_BASE 10'h110
`define ARFR_SPR_SUP_COUNT 4
`define ARFR_MSR_USER_BIT 14
`define ARFR_MSR_RESET 32'h00000000
`endif

// ### hw/arfr_pkg.sv
// Types for the architectural register file with rename buffers
`include "arfr_consts.svh"
package arfr_pkg;
  typedef logic [`ARFR_INT_TAG_W-1:0] arfr_itag_type;
  typedef logic [`ARFR_FP_TAG_W-1:0] arfr_ftag_type;
  typedef logic [`ARFR_REG_IDX_W-1:0] arfr_idx_type;

  typedef struct packed {
    logic ready;
    arfr_itag_type tag;
    logic [`ARFR_INT_W-1:0] data;
  } arfr_int_op_type;

  typedef struct packed {
    logic ready;
    arfr_ftag_type tag;
    logic single;
    logic [`ARFR_FP_W-1:0] data;
  } arfr_fp_op_type;

  typedef struct packed {
    logic [`ARFR_NUM_REGS-1:0][`ARFR_INT_W-1:0] general_register;
    logic [`ARFR_NUM_REGS-1:0][`ARFR_FP_W-1:0] float_register;
    logic [`ARFR_NUM_REGS-1:0] fpr_single;
    logic [`ARFR_INT_RB-1:0][`ARFR_INT_W-1:0] ib_data;
    logic [`ARFR_INT_RB-1:0][`ARFR_REG_IDX_W-1:0] ib_dest;
    logic [`ARFR_INT_RB-1:0] ib_done;
    arfr_itag_type ib_head;
    arfr_itag_type ib_tail;
    logic [`ARFR_INT_TAG_W-1:0] ib_count;
    logic [`ARFR_FP_RB-1:0][`ARFR_FP_W-1:0] fb_data;
    logic [`ARFR_FP_RB-1:0][`ARFR_REG_IDX_W-1:0] fb_dest;
    logic [`ARFR_FP_RB-1:0] fb_done;
    logic [`ARFR_FP_RB-1:0] fb_single;
    arfr_ftag_type fb_head;
    arfr_ftag_type fb_tail;
    logic [`ARFR_FP_TAG_W:0] fb_count;
    logic [`ARFR_NUM_REGS-1:0] int_map_valid;
    logic [`ARFR_NUM_REGS-1:0][`ARFR_INT_TAG_W-1:0] int_map_tag;
    logic [`ARFR_NUM_REGS-1:0] fp_map_valid;
    logic [`ARFR_NUM_REGS-1:0][`ARFR_FP_TAG_W-1:0] fp_map_tag;
    logic [`ARFR_INT_W-1:0] machine_state_register;
    logic [`ARFR_INT_W-1:0] spr_user;
    logic [`ARFR_SPR_SUP_COUNT-1:0][`ARFR_INT_W-1:0] spr_sup;
    logic int_ready;
    logic fp_ready;
    logic disp_ack;
    logic [`ARFR_INT_TAG_W-1:0] disp_tag;
    arfr_int_op_type op_a;
    arfr_int_op_type op_b;
    arfr_fp_op_type op_f;
    logic [`ARFR_FP_W-1:0] arch_rd_data;
    logic arch_rd_single;
    logic [`ARFR_INT_W-1:0] spr_rdata;
    logic exc_illegal;
    logic exc_privileged;
  } arfr_state_type;
endpackage

// ### hw/arfr_regfile.sv
// Architectural register file with integer and float rename buffers
`include "arfr_consts.svh"
module arfr_regfile (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire logic disp_valid,
  input wire logic disp_is_fp,
  input wire logic disp_fp_single,
  input wire logic [4:0] disp_dest,
  output logic disp_int_ready,
  output logic disp_fp_ready,
  output logic disp_ack,
  output logic [3:0] disp_tag,
  input wire logic int_res_valid,
  input wire logic [3:0] int_res_tag,
  input wire logic [31:0] int_res_data,
  input wire logic fp_res_valid,
  input wire logic [2:0] fp_res_tag,
  input wire logic [63:0] fp_res_data,
  input wire logic [4:0] op_a_reg,
  input wire logic [4:0] op_b_reg,
  input wire logic op_b_use_imm,
  input wire logic [31:0] op_b_imm,
  input wire logic [4:0] op_f_reg,
  output logic [31:0] op_a_data,
  output logic op_a_ready,
  output logic [3:0] op_a_tag,
  output logic [31:0] op_b_data,
  output logic op_b_ready,
  output logic [3:0] op_b_tag,
  output logic [63:0] op_f_data,
  output logic op_f_single,
  output logic op_f_ready,
  output logic [2:0] op_f_tag,
  input wire logic arch_rd_fp,
  input wire logic [4:0] arch_rd_idx,
  output logic [63:0] arch_rd_data,
  output logic arch_rd_single,
  input wire logic instr_valid,
  input wire logic instr_is64,
  input wire logic instr_priv,
  input wire logic spr_valid,
  input wire logic spr_write,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  input wire logic msr_write,
  input wire logic [31:0] msr_wdata,
  output logic [31:0] spr_rdata,
  output logic user_mode,
  output logic exc_illegal,
  output logic exc_privileged
);
  // ****************************************************************
  // Reset release and state
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  arfr_pkg::arfr_state_type s_reg;
  arfr_pkg::arfr_state_type s_next;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic arfr_pkg::arfr_itag_type inc_itag(
      arfr_pkg::arfr_itag_type t);
    return (t == `ARFR_INT_TAG_LAST) ? '0 : t + 4'h1;
  endfunction

  // Newest in-flight producer wins; retired value otherwise
  function automatic arfr_pkg::arfr_int_op_type int_lookup(
      arfr_pkg::arfr_state_type st, arfr_pkg::arfr_idx_type r);
    arfr_pkg::arfr_int_op_type o;
    o.tag = st.int_map_tag[r];
    o.ready = 1'b1;
    o.data = st.general_register[r];
    if (st.int_map_valid[r]) begin
      o.ready = st.ib_done[o.tag];
      o.data = st.ib_data[o.tag];
    end
    return o;
  endfunction

  function automatic logic is_supervisor_spr(logic [9:0] n);
    return n[`ARFR_SPR_PRIV_BIT];
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic ia;
    logic ir;
    logic fa;
    logic fr;
    logic user;
    logic [9:0] sup_off;
    arfr_pkg::arfr_idx_type d;
    ia = 1'b0;
    ir = 1'b0;
    fa = 1'b0;
    fr = 1'b0;
    d = '0;
    user = s_reg.machine_state_register[`ARFR_MSR_USER_BIT];
    sup_off = spr_num - `ARFR_SPR_SUP_BASE;
    s_next = s_reg;
    if (enable) begin
      s_next.disp_ack = 1'b0;
      s_next.exc_illegal = 1'b0;
      s_next.exc_privileged = 1'b0;
      // Retire the oldest integer result, strictly in order
      if (s_reg.ib_count != '0 && s_reg.ib_done[s_reg.ib_head]) begin
        ir = 1'b1;
        d = s_reg.ib_dest[s_reg.ib_head];
        s_next.general_register[d] = s_reg.ib_data[s_reg.ib_head];
        if (s_reg.int_map_tag[d] == s_reg.ib_head) begin
          s_next.int_map_valid[d] = 1'b0;
        end
        s_next.ib_head = inc_itag(s_reg.ib_head);
      end
      if (s_reg.fb_count != '0 && s_reg.fb_done[s_reg.fb_head]) begin
        fr = 1'b1;
        d = s_reg.fb_dest[s_reg.fb_head];
        s_next.float_register[d] = s_reg.fb_data[s_reg.fb_head];
        s_next.fpr_single[d] = s_reg.fb_single[s_reg.fb_head];
        if (s_reg.fp_map_tag[d] == s_reg.fb_head) begin
          s_next.fp_map_valid[d] = 1'b0;
        end
        s_next.fb_head = s_reg.fb_head + 3'h1;
      end
      // Results land in their buffer; only execution and load paths write
      if (int_res_valid) begin
        s_next.ib_data[int_res_tag] = int_res_data;
        s_next.ib_done[int_res_tag] = 1'b1;
      end
      if (fp_res_valid) begin
        s_next.fb_data[fp_res_tag] = fp_res_data;
        s_next.fb_done[fp_res_tag] = 1'b1;
      end
      // Allocation: refused while the class has no free buffer
      if (disp_valid && !disp_is_fp && s_reg.int_ready) begin
        ia = 1'b1;
        s_next.ib_dest[s_reg.ib_tail] = disp_dest;
        s_next.ib_done[s_reg.ib_tail] = 1'b0;
        s_next.int_map_valid[disp_dest] = 1'b1;
        s_next.int_map_tag[disp_dest] = s_reg.ib_tail;
        s_next.ib_tail = inc_itag(s_reg.ib_tail);
        s_next.disp_tag = s_reg.ib_tail;
        s_next.disp_ack = 1'b1;
      end
      if (disp_valid && disp_is_fp && s_reg.fp_ready) begin
        fa = 1'b1;
        s_next.fb_dest[s_reg.fb_tail] = disp_dest;
        s_next.fb_done[s_reg.fb_tail] = 1'b0;
        s_next.fb_single[s_reg.fb_tail] = disp_fp_single;
        s_next.fp_map_valid[disp_dest] = 1'b1;
        s_next.fp_map_tag[disp_dest] = s_reg.fb_tail;
        s_next.fb_tail = s_reg.fb_tail + 3'h1;
        s_next.disp_tag = {1'b0, s_reg.fb_tail};
        s_next.disp_ack = 1'b1;
      end
      s_next.ib_count = s_reg.ib_count + {3'h0, ia} - {3'h0, ir};
      s_next.fb_count = s_reg.fb_count + {3'h0, fa} - {3'h0, fr};
      s_next.int_ready = s_next.ib_count < `ARFR_INT_RB;
      s_next.fp_ready = s_next.fb_count < `ARFR_FP_RB;
      // Operand reads see buffered results early
      s_next.op_a = int_lookup(s_reg, op_a_reg);
      s_next.op_b = int_lookup(s_reg, op_b_reg);
      if (op_b_use_imm) begin
        s_next.op_b.ready = 1'b1;
        s_next.op_b.tag = '0;
        s_next.op_b.data = op_b_imm;
      end
      s_next.op_f.tag = s_reg.fp_map_tag[op_f_reg];
      s_next.op_f.ready = 1'b1;
      s_next.op_f.data = s_reg.float_register[op_f_reg];
      s_next.op_f.single = s_reg.fpr_single[op_f_reg];
      if (s_reg.fp_map_valid[op_f_reg]) begin
        s_next.op_f.ready = s_reg.fb_done[s_next.op_f.tag];
        s_next.op_f.data = s_reg.fb_data[s_next.op_f.tag];
        s_next.op_f.single = s_reg.fb_single[s_next.op_f.tag];
      end
      // Architectural view hides the rename buffers
      if (arch_rd_fp) begin
        s_next.arch_rd_data = s_reg.float_register[arch_rd_idx];
        s_next.arch_rd_single = s_reg.fpr_single[arch_rd_idx];
      end else begin
        s_next.arch_rd_data = {32'h00000000, s_reg.general_register[arch_rd_idx]};
        s_next.arch_rd_single = 1'b0;
      end
      // Instruction checks: illegal outranks privileged
      if (instr_valid && instr_is64) begin
        s_next.exc_illegal = 1'b1;
      end else if (instr_valid && instr_priv && user) begin
        s_next.exc_privileged = 1'b1;
      end
      if (msr_write) begin
        if (user) begin
          s_next.exc_privileged = 1'b1;
        end else begin
          s_next.machine_state_register = msr_wdata;
        end
      end
      // Special register moves by fixed number
      if (spr_valid) begin
        if (is_supervisor_spr(spr_num) && user) begin
          s_next.exc_privileged = 1'b1;
        end else if (spr_num == `ARFR_SPR_USER_NUM) begin
          if (spr_write) begin
            s_next.spr_user = spr_wdata;
          end
          s_next.spr_rdata = s_reg.spr_user;
        end else if (sup_off < `ARFR_SPR_SUP_COUNT) begin
          if (spr_write) begin
            s_next.spr_sup[sup_off[1:0]] = spr_wdata;
          end
          s_next.spr_rdata = s_reg.spr_sup[sup_off[1:0]];
        end else begin
          s_next.exc_illegal = 1'b1;
          s_next.spr_rdata = 32'h00000000;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      s_reg <= '0;
      s_reg.machine_state_register <= `ARFR_MSR_RESET;
      s_reg.int_ready <= 1'b1;
      s_reg.fp_ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign disp_int_ready = s_reg.int_ready;
  assign disp_fp_ready = s_reg.fp_ready;
  assign disp_ack = s_reg.disp_ack;
  assign disp_tag = s_reg.disp_tag;
  assign op_a_data = s_reg.op_a.data;
  assign op_a_ready = s_reg.op_a.ready;
  assign op_a_tag = s_reg.op_a.tag;
  assign op_b_data = s_reg.op_b.data;
  assign op_b_ready = s_reg.op_b.ready;
  assign op_b_tag = s_reg.op_b.tag;
  assign op_f_data = s_reg.op_f.data;
  assign op_f_single = s_reg.op_f.single;
  assign op_f_ready = s_reg.op_f.ready;
  assign op_f_tag = s_reg.op_f.tag;
  assign arch_rd_data = s_reg.arch_rd_data;
  assign arch_rd_single = s_reg.arch_rd_single;
  assign spr_rdata = s_reg.spr_rdata;
  assign user_mode = s_reg.machine_state_register[`ARFR_MSR_USER_BIT];
  assign exc_illegal = s_reg.exc_illegal;
  assign exc_privileged = s_reg.exc_privileged;
endmodule // arfr_regfile

// ### verification/arfr_checker.sv
// Concurrent checks on the register file ports
// ****
// Checker
// ****
module arfr_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire logic disp_valid,
  input wire logic disp_is_fp,
  input wire logic disp_ack,
  input wire logic disp_int_ready,
  input wire logic op_b_use_imm,
  input wire logic [31:0] op_b_imm,
  input wire logic [31:0] op_b_data,
  input wire logic arch_rd_fp,
  input wire logic [63:0] arch_rd_data,
  input wire logic instr_valid,
  input wire logic instr_is64,
  input wire logic instr_priv,
  input wire logic msr_write,
  input wire logic [31:0] msr_wdata,
  input wire logic user_mode,
  input wire logic exc_illegal,
  input wire logic exc_privileged
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_ack;
    disp_ack && $past(enable) |-> $past(disp_valid);
  endproperty
  a_ack: assert property (p_ack) else $error("ack with no request");
  property p_full;
    enable && disp_valid && !disp_is_fp && !disp_int_ready |=> !disp_ack;
  endproperty
  a_full: assert property (p_full) else $error("ack while full");
  property p_is64;
    enable && instr_valid && instr_is64 |=> exc_illegal && !exc_privileged;
  endproperty
  a_is64: assert property (p_is64) else $error("wide op ran");
  property p_upriv;
    enable && instr_valid && !instr_is64 && instr_priv && user_mode
      |=> exc_privileged;
  endproperty
  a_upriv: assert property (p_upriv) else $error("user ran priv");
  property p_msrset;
    enable && msr_write && !user_mode |=> user_mode == $past(msr_wdata[14]);
  endproperty
  a_msrset: assert property (p_msrset) else $error("mode bit");
  property p_msruser;
    enable && msr_write && user_mode |=> user_mode && exc_privileged;
  endproperty
  a_msruser: assert property (p_msruser) else $error("msr in user");
  property p_imm;
    enable && op_b_use_imm |=> op_b_data == $past(op_b_imm);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate lost");
  property p_width;
    enable && !arch_rd_fp |=> arch_rd_data[63:32] == 32'h00000000;
  endproperty
  a_width: assert property (p_width) else $error("int read wide");
endmodule // arfr_checker

bind arfr_regfile arfr_checker u_chk (.*);

// ### verification/arfr_exec_model.sv
// Execution unit model returning one result after a set latency
module arfr_exec_model #(
  parameter int DW = 32,
  parameter int TW = 4,
  parameter int LAT = 1
) (
  input wire logic clock,
  input wire logic start,
  input wire logic [TW-1:0] tag,
  input wire logic [DW-1:0] value,
  output logic res_valid,
  output logic [TW-1:0] res_tag,
  output logic [DW-1:0] res_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [TW-1:0] t;
  logic [DW-1:0] v;
  initial res_valid = 1'h0;
  // Idle lines carry the inverse so a stale value can never match
  always @(posedge clock) begin
    if (start) begin
      t = tag;
      v = value;
      repeat (LAT) @(posedge clock);
      #1 res_valid = 1'h1;
      res_tag = t;
      res_data = v;
      @(posedge clock);
      #1 res_valid = 1'h0;
      res_tag = ~t;
      res_data = ~v;
    end
  end
endmodule // arfr_exec_model

// ### verification/test_arfr_regfile.sv
// Self-checking testbench for the register file with rename buffers
module test_arfr_regfile;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and partners
  // ****
  logic clock = '0, resetn = '0, enable = '1, disp_valid = '0;
  logic disp_is_fp = '0, disp_fp_single = '0, op_b_use_imm = '0;
  logic arch_rd_fp = '0, instr_valid = '0, instr_is64 = '0;
  logic instr_priv = '0, spr_valid = '0, spr_write = '0, msr_write = '0;
  logic ist = '0, fst = '0;
  logic [2:0] ftag = '0;
  logic [3:0] itag = '0;
  logic [4:0] disp_dest = '0, op_a_reg = '0, op_b_reg = '0;
  logic [4:0] op_f_reg = '0, arch_rd_idx = '0;
  logic [9:0] spr_num = '0;
  logic [31:0] op_b_imm = '0, spr_wdata = '0, msr_wdata = '0, idat = '0;
  logic [63:0] fdat = '0;
  logic disp_int_ready, disp_fp_ready, disp_ack, int_res_valid;
  logic fp_res_valid, op_a_ready, op_b_ready, op_f_single, op_f_ready;
  logic arch_rd_single, user_mode, exc_illegal, exc_privileged;
  logic [2:0] fp_res_tag, op_f_tag;
  logic [3:0] disp_tag, int_res_tag, op_a_tag, op_b_tag;
  logic [31:0] int_res_data, op_a_data, op_b_data, spr_rdata;
  logic [63:0] fp_res_data, op_f_data, arch_rd_data;
  int errors = 0, tests_run = 0, cycles = 0;
  arfr_regfile dut (.*);
  arfr_exec_model int_unit (.clock(clock),
    .start(ist), .tag(itag), .value(idat), .res_valid(int_res_valid),
    .res_tag(int_res_tag), .res_data(int_res_data));
  arfr_exec_model #(.DW(64), .TW(3), .LAT(4)) fp_unit (.clock(clock),
    .start(fst), .tag(ftag), .value(fdat), .res_valid(fp_res_valid),
    .res_tag(fp_res_tag), .res_data(fp_res_data));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict;
    end
  end
  // ****
  // Tasks
  // ****
  task tick;
    @(posedge clock);
    #1;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task disp(input logic fp, input logic [4:0] d, input logic a,
    input logic [3:0] t);
    tick;
    disp_valid = 1'h1;
    disp_is_fp = fp;
    disp_fp_single = d[0];
    disp_dest = d;
    tick;
    disp_valid = 1'h0;
    chk(disp_ack, a, "ack");
    if (a) chk(disp_tag, t, "tag");
  endtask
  task ires(input logic [3:0] t, input logic [31:0] v);
    ist = 1'h1;
    itag = t;
    idat = v;
    tick;
    ist = 1'h0;
    repeat (3) tick;
  endtask
  task fres(input logic [2:0] t, input logic [63:0] v);
    fst = 1'h1;
    ftag = t;
    fdat = v;
    tick;
    fst = 1'h0;
    repeat (6) tick;
  endtask
  task rd(input logic fp, input logic [4:0] i, input logic [63:0] e);
    arch_rd_fp = fp;
    arch_rd_idx = i;
    tick;
    chk(arch_rd_data, e, "arch read");
  endtask
  task special_register(input logic w, input logic [9:0] n, input logic [31:0] d);
    tick;
    spr_valid = 1'h1;
    spr_write = w;
    spr_num = n;
    spr_wdata = d;
    tick;
    spr_valid = 1'h0;
  endtask
  task instr(input logic w, input logic p);
    tick;
    instr_valid = 1'h1;
    instr_is64 = w;
    instr_priv = p;
    tick;
    instr_valid = 1'h0;
  endtask
  task machine_state_register(input logic [31:0] d);
    msr_write = 1'h1;
    msr_wdata = d;
    tick;
    msr_write = 1'h0;
  endtask
  // ****
  // Scenarios
  // ****
  task t_int;
    for (int i = 0; i < 12; i++) begin
      disp(1'h0, 5'(i + 1), 1'h1, 4'(i));
      chk(disp_int_ready, i != 11, "int ready");
    end
    disp(1'h0, 5'h0D, 1'h0, 4'h0);
    enable = 1'h0;
    disp(1'h0, 5'h0D, 1'h0, 4'h0);
    enable = 1'h1;
    op_a_reg = 5'h02;
    tick;
    chk(op_a_ready, 1'h0, "pending");
    chk(op_a_tag, 4'h1, "pending tag");
    for (int i = 11; i > 0; i--) ires(4'(i), 32'hA0000000 + 32'(i));
    rd(1'h0, 5'h0C, 64'h0);
    chk(disp_int_ready, 1'h0, "early retire");
    ires(4'h0, 32'hA0000000);
    repeat (12) tick;
    for (int i = 0; i < 12; i++) rd(1'h0, 5'(i + 1), 32'hA0000000 + i);
    chk(op_a_data, 32'hA0000001, "operand");
    disp(1'h0, 5'h05, 1'h1, 4'h0);
    op_a_reg = 5'h05;
    op_b_reg = 5'h05;
    op_b_use_imm = 1'h1;
    op_b_imm = 32'h12345678;
    tick;
    op_b_use_imm = 1'h0;
    chk(op_a_ready, 1'h0, "rename");
    chk(op_b_data, 32'h12345678, "imm");
    ires(4'h0, 32'h5A5A5A5A);
    chk(op_a_data, 32'h5A5A5A5A, "fwd");
    chk(op_b_ready, 1'h1, "fwd b ready");
    chk(op_b_data, 32'h5A5A5A5A, "fwd b");
    chk(op_b_tag, 4'h0, "fwd b tag");
    rd(1'h0, 5'h05, 64'h5A5A5A5A);
  endtask
  task t_fp;
    for (int i = 0; i < 8; i++) begin
      disp(1'h1, 5'(i), 1'h1, 4'(i));
      chk(disp_fp_ready, i != 7, "fp ready");
    end
    disp(1'h1, 5'h08, 1'h0, 4'h0);
    op_f_reg = 5'h02;
    tick;
    chk(op_f_ready, 1'h0, "fp pending");
    chk(op_f_tag, 3'h2, "fp tag");
    for (int i = 0; i < 8; i++) fres(3'(i), 64'hC000000000000000 + i);
    for (int i = 0; i < 8; i++) begin
      rd(1'h1, 5'(i), 64'hC000000000000000 + i);
      chk(arch_rd_single, i % 2, "format");
    end
    op_f_reg = 5'h03;
    tick;
    chk(op_f_data, 64'hC000000000000003, "fp op");
    chk(op_f_ready, 1'h1, "fp op ready");
    chk(op_f_single, 1'h1, "fp op format");
  endtask
  task t_priv;
    special_register(1'h1, 10'h110, 32'hCAFE0001);
    special_register(1'h0, 10'h110, 32'h0);
    chk(spr_rdata, 32'hCAFE0001, "spr");
    special_register(1'h0, 10'h1FF, 32'h0);
    chk(exc_illegal, 1'h1, "bad num");
    instr(1'h1, 1'h1);
    chk(exc_illegal, 1'h1, "wide");
    instr(1'h0, 1'h1);
    chk(exc_privileged, 1'h0, "sup");
    machine_state_register(32'h00004000);
    chk(user_mode, 1'h1, "mode");
    instr(1'h0, 1'h1);
    chk(exc_privileged, 1'h1, "user priv");
    special_register(1'h1, 10'h111, 32'h1);
    chk(exc_privileged, 1'h1, "sup spr");
    special_register(1'h1, 10'h100, 32'h0000BEEF);
    special_register(1'h0, 10'h100, 32'h0);
    chk(spr_rdata, 32'h0000BEEF, "user spr");
    machine_state_register(32'h0);
    chk(user_mode, 1'h1, "msr held");
    resetn = 1'h0;
    repeat (3) tick;
    resetn = 1'h1;
    repeat (4) tick;
    chk(user_mode, 1'h0, "reset mode");
  endtask
  task give_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) tick;
    resetn = 1'h1;
    repeat (4) tick;
    chk(disp_fp_ready, 1'h1, "reset");
    t_int;
    t_fp;
    t_priv;
    give_verdict;
  end
endmodule // test_arfr_regfile
